// >>> core/frss_host.sv
// wishbone-controlled host sequencer for reset, commands and status polling
module frss_host
    import frss_pkg::*;
#(
    parameter int ADDR_W        = 21,
    parameter int TO_W          = 32,
    parameter int PERASE_TO_US  = PERASE_MAX_US,
    parameter int MERASE_TO_US  = MERASE_MAX_US,
    parameter int CHIP_TO_US    = CHIP_MAX_US,
    parameter int GAP_LIMIT_US  = GAP_US
)(
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [7:0]        wb_adr_i,
    input  wire logic [31:0]       wb_dat_i,
    input  wire logic [3:0]        wb_sel_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    output logic                   irq_o,
    output logic                   flash_rst_n_o,
    output logic                   flash_ce_n_o,
    output logic                   flash_we_n_o,
    output logic                   flash_oe_n_o,
    output logic      [ADDR_W-1:0] flash_addr_o,
    input  wire logic [15:0]       flash_dq_i,
    output logic      [15:0]       flash_dq_o,
    output logic                   flash_dq_oe_o
);
    // refuse settings the counters cannot hold
    if (ADDR_W < 1 || ADDR_W > 32 || TO_W < 29 || TO_W > 32 ||
        GAP_LIMIT_US < 1 || GAP_LIMIT_US > 65535) begin : g_bad_param
        $error("frss_host: unsupported parameter value");
    end

    localparam logic [15:0] GAP_LIM = 16'(GAP_LIMIT_US);

    frss_tmr_if #(.W(TO_W)) tmr ();

    frss_timer #(.W(TO_W)) u_timer (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .t     (tmr)
    );

    // sequencer state
    frss_state_e       st_reg,    st_next;
    logic [7:0]        cnt_reg,   cnt_next;
    frss_kind_e        kind_reg,  kind_next;
    logic              glob_reg,  glob_next;
    logic              poll_reg,  poll_next;
    logic              rtmr_reg,  rtmr_next;
    logic              opact_reg, opact_next;
    logic [15:0]       gap_reg,   gap_next;
    logic [15:0]       sts_reg,   sts_next;
    logic              rstn_reg,  rstn_next;
    logic              ce_reg,    ce_next;
    logic              we_reg,    we_next;
    logic              oe_reg,    oe_next;
    logic [ADDR_W-1:0] fa_reg,    fa_next;
    logic [15:0]       dq_reg,    dq_next;
    logic              dqoe_reg,  dqoe_next;
    // bus state
    logic [ADDR_W-1:0] addr_reg,  addr_next;
    logic [15:0]       wdat_reg,  wdat_next;
    logic [IRQ_W-1:0]  mask_reg,  mask_next;
    logic [IRQ_W-1:0]  irqs_reg,  irqs_next;
    logic              ack_reg,   ack_next;
    logic [31:0]       rdat_reg,  rdat_next;
    logic              irq_reg,   irq_next;
    // links between the two groups
    logic              wr_ctrl;
    logic [IRQ_W-1:0]  evt;
    logic              launch;
    logic              ready_bit;
    logic              is_op;
    logic [TO_W-1:0]   op_limit;

    // erase or program kinds keep the engine busy
    // decoded from the written kind field, so no loop through kind_next
    assign is_op = wb_dat_i[CTRL_KIND_LSB +: 3] inside {KIND_PROG, KIND_PERASE,
                   KIND_MERASE, KIND_CHIP, KIND_ERES};
    // global bit when strobe timing is doubtful, else partition bit
    assign ready_bit = glob_reg ? sts_reg[ALL_PARTITIONS_READY_BIT]
                                : sts_reg[PARTITION_READY_BIT];

    // timeout chosen per operation kind
    always_comb begin
        unique case (kind_reg)
            KIND_PROG:   op_limit = TO_W'(PROG_MAX_US);
            KIND_PERASE: op_limit = TO_W'(PERASE_TO_US);
            KIND_MERASE: op_limit = TO_W'(MERASE_TO_US);
            KIND_ERES:   op_limit = TO_W'(MERASE_TO_US);
            KIND_CHIP:   op_limit = TO_W'(CHIP_TO_US);
            KIND_PSUS:   op_limit = TO_W'(PSUS_MAX_US);
            KIND_ESUS:   op_limit = TO_W'(ESUS_MAX_US);
            KIND_PLAIN:  op_limit = '0;
        endcase
    end

    // sequencer next state
    always_comb begin
        st_next    = st_reg;
        cnt_next   = (cnt_reg != 8'h00) ? cnt_reg - 8'h01 : 8'h00;
        kind_next  = kind_reg;
        glob_next  = glob_reg;
        poll_next  = poll_reg;
        rtmr_next  = rtmr_reg;
        opact_next = opact_reg;
        gap_next   = (tmr.us_tick && gap_reg < GAP_LIM) ? gap_reg + 16'h0001 : gap_reg;
        sts_next   = sts_reg;
        rstn_next  = rstn_reg;
        ce_next    = ce_reg;
        we_next    = we_reg;
        oe_next    = oe_reg;
        fa_next    = fa_reg;
        dq_next    = dq_reg;
        dqoe_next  = dqoe_reg;
        evt        = '0;
        launch     = 1'b0;
        tmr.start  = 1'b0;
        tmr.limit  = op_limit;
        if (wr_ctrl && st_reg != ST_IDLE) begin
            evt[IRQ_REFUSED] = 1'b1;
        end
        unique case (st_reg)
            ST_IDLE: begin
                if (wr_ctrl && wb_dat_i[CTRL_RST_BIT]) begin
                    rstn_next = 1'b0;
                    ce_next   = 1'b1;
                    we_next   = 1'b1;
                    oe_next   = 1'b1;
                    dqoe_next = 1'b0;
                    rtmr_next = opact_reg;
                    tmr.start = 1'b1;
                    tmr.limit = TO_W'(RST_ABORT_US);
                    cnt_next  = 8'(RST_READ_CYC - 1);
                    st_next   = ST_RST_LOW;
                end else if (wr_ctrl && wb_dat_i[CTRL_CMD_BIT]) begin
                    kind_next = frss_kind_e'(wb_dat_i[CTRL_KIND_LSB +: 3]);
                    glob_next = wb_dat_i[CTRL_GLOBAL_BIT];
                    if (is_op && opact_reg) begin
                        evt[IRQ_REFUSED] = 1'b1;
                    end else if (kind_next == KIND_ESUS && gap_reg < GAP_LIM) begin
                        st_next = ST_GAP;
                    end else begin
                        launch = 1'b1;
                    end
                end else if (wr_ctrl && wb_dat_i[CTRL_RD_BIT]) begin
                    glob_next = wb_dat_i[CTRL_GLOBAL_BIT];
                    poll_next = 1'b0;
                    fa_next   = addr_reg;
                    ce_next   = 1'b0;
                    oe_next   = 1'b0;
                    cnt_next  = 8'(RD_LOW_CYC - 1);
                    st_next   = ST_RD_LOW;
                end
            end
            ST_GAP: begin
                if (gap_reg >= GAP_LIM) begin
                    launch = 1'b1;
                end
            end
            ST_RST_LOW: begin
                if ((rtmr_reg && tmr.expired) || (!rtmr_reg && cnt_reg == 8'h00)) begin
                    rstn_next  = 1'b1;
                    opact_next = 1'b0;
                    cnt_next   = 8'(RECOVERY_CYC - 1);
                    st_next    = ST_RST_REC;
                end
            end
            ST_RST_REC: begin
                if (cnt_reg == 8'h00) begin
                    evt[IRQ_DONE] = 1'b1;
                    st_next       = ST_IDLE;
                end
            end
            ST_WR_LOW: begin
                if (cnt_reg == 8'h00) begin
                    ce_next  = 1'b1;
                    we_next  = 1'b1;
                    cnt_next = 8'(STROBE_HIGH_CYC - 1);
                    st_next  = ST_WR_HIGH;
                end
            end
            ST_WR_HIGH: begin
                dqoe_next = 1'b0;
                if (kind_reg == KIND_PLAIN) begin
                    evt[IRQ_DONE] = 1'b1;
                    st_next       = ST_IDLE;
                end else begin
                    if (kind_reg == KIND_ERES) begin
                        gap_next = 16'h0000;
                    end
                    if (kind_reg == KIND_PSUS || kind_reg == KIND_ESUS) begin
                        opact_next = 1'b0;
                    end else begin
                        opact_next = 1'b1;
                    end
                    poll_next = 1'b1;
                    tmr.start = 1'b1;
                    cnt_next  = 8'(READY_DROP_CYC - 1);
                    st_next   = ST_SETTLE;
                end
            end
            ST_SETTLE: begin
                if (cnt_reg == 8'h00) begin
                    fa_next  = addr_reg;
                    ce_next  = 1'b0;
                    oe_next  = 1'b0;
                    cnt_next = 8'(RD_LOW_CYC - 1);
                    st_next  = ST_RD_LOW;
                end
            end
            ST_RD_LOW: begin
                if (cnt_reg == 8'h00) begin
                    sts_next = flash_dq_i;
                    ce_next  = 1'b1;
                    oe_next  = 1'b1;
                    cnt_next = 8'(STROBE_HIGH_CYC - 1);
                    st_next  = ST_RD_GAP;
                end
            end
            ST_RD_GAP: begin
                if (cnt_reg == 8'h00) begin
                    if (!poll_reg || ready_bit) begin
                        if (poll_reg && sts_reg[ALL_PARTITIONS_READY_BIT]) begin
                            opact_next = 1'b0;
                        end
                        evt[IRQ_DONE] = 1'b1;
                        st_next       = ST_IDLE;
                    end else if (tmr.expired) begin
                        evt[IRQ_TIMEOUT] = 1'b1;
                        st_next          = ST_IDLE;
                    end else begin
                        ce_next  = 1'b0;
                        oe_next  = 1'b0;
                        cnt_next = 8'(RD_LOW_CYC - 1);
                        st_next  = ST_RD_LOW;
                    end
                end
            end
        endcase
        // start a command write cycle
        if (launch) begin
            fa_next   = addr_reg;
            dq_next   = wdat_reg;
            dqoe_next = 1'b1;
            ce_next   = 1'b0;
            we_next   = 1'b0;
            cnt_next  = 8'(WE_LOW_CYC - 1);
            st_next   = ST_WR_LOW;
        end
    end

    // sequencer registers; power-up starts with reset held low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            st_reg    <= ST_RST_LOW;
            cnt_reg   <= 8'(RST_READ_CYC - 1);
            kind_reg  <= KIND_PLAIN;
            glob_reg  <= 1'b0;
            poll_reg  <= 1'b0;
            rtmr_reg  <= 1'b0;
            opact_reg <= 1'b0;
            gap_reg   <= GAP_LIM;
            sts_reg   <= 16'h0000;
            rstn_reg  <= 1'b0;
            ce_reg    <= 1'b1;
            we_reg    <= 1'b1;
            oe_reg    <= 1'b1;
            fa_reg    <= '0;
            dq_reg    <= 16'h0000;
            dqoe_reg  <= 1'b0;
        end else begin
            st_reg    <= st_next;
            cnt_reg   <= cnt_next;
            kind_reg  <= kind_next;
            glob_reg  <= glob_next;
            poll_reg  <= poll_next;
            rtmr_reg  <= rtmr_next;
            opact_reg <= opact_next;
            gap_reg   <= gap_next;
            sts_reg   <= sts_next;
            rstn_reg  <= rstn_next;
            ce_reg    <= ce_next;
            we_reg    <= we_next;
            oe_reg    <= oe_next;
            fa_reg    <= fa_next;
            dq_reg    <= dq_next;
            dqoe_reg  <= dqoe_next;
        end
    end

    // wishbone slave: one-cycle ack, byte lanes, w1c interrupt status
    logic        bus_wr;
    logic [31:0] wmask;
    assign bus_wr  = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;
    assign wmask   = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
    assign wr_ctrl = bus_wr && wb_adr_i[7:2] == REG_CTRL[7:2] && wb_sel_i[0];

    always_comb begin
        ack_next  = wb_cyc_i && wb_stb_i && !ack_reg;
        addr_next = addr_reg;
        wdat_next = wdat_reg;
        mask_next = mask_reg;
        irqs_next = irqs_reg | evt;
        rdat_next = rdat_reg;
        if (bus_wr) begin
            unique case (wb_adr_i[7:2])
                REG_ADDR[7:2]:  addr_next = ADDR_W'((32'(addr_reg) & ~wmask) | (wb_dat_i & wmask));
                REG_WDATA[7:2]: wdat_next = (wdat_reg & ~wmask[15:0]) | (wb_dat_i[15:0] & wmask[15:0]);
                REG_MASK[7:2]:  mask_next = (mask_reg & ~wmask[IRQ_W-1:0]) |
                                            (wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]);
                REG_IRQS[7:2]:  irqs_next = (irqs_reg & ~(wb_dat_i[IRQ_W-1:0] & wmask[IRQ_W-1:0]))
                                            | evt;  // set wins over clear
                default:        addr_next = addr_reg;
            endcase
        end
        if (wb_cyc_i && wb_stb_i && !ack_reg) begin
            rdat_next = 32'h0000_0000;
            unique case (wb_adr_i[7:2])
                REG_CTRL[7:2]:  rdat_next = 32'({kind_reg, glob_reg, 3'h0});
                REG_ADDR[7:2]:  rdat_next = 32'(addr_reg);
                REG_WDATA[7:2]: rdat_next = 32'(wdat_reg);
                REG_STAT[7:2]:  rdat_next = {14'h0000, opact_reg, st_reg != ST_IDLE, sts_reg};
                REG_IRQS[7:2]:  rdat_next = 32'(irqs_reg);
                REG_MASK[7:2]:  rdat_next = 32'(mask_reg);
                default:        rdat_next = 32'h0000_0000;
            endcase
        end
        irq_next = |(irqs_next & mask_next);
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg  <= 1'b0;
            addr_reg <= '0;
            wdat_reg <= 16'h0000;
            mask_reg <= IRQ_MASK_RST;
            irqs_reg <= '0;
            rdat_reg <= 32'h0000_0000;
            irq_reg  <= 1'b0;
        end else begin
            ack_reg  <= ack_next;
            addr_reg <= addr_next;
            wdat_reg <= wdat_next;
            mask_reg <= mask_next;
            irqs_reg <= irqs_next;
            rdat_reg <= rdat_next;
            irq_reg  <= irq_next;
        end
    end

    // outputs straight from flops
    assign wb_ack_o      = ack_reg;
    assign wb_dat_o      = rdat_reg;
    assign irq_o         = irq_reg;
    assign flash_rst_n_o = rstn_reg;
    assign flash_ce_n_o  = ce_reg;
    assign flash_we_n_o  = we_reg;
    assign flash_oe_n_o  = oe_reg;
    assign flash_addr_o  = fa_reg;
    assign flash_dq_o    = dq_reg;
    assign flash_dq_oe_o = dqoe_reg;
endmodule // frss_host

// >>> core/frss_pkg.sv
// constants, register map and state codes of the flash reset/suspend host
// Summary of operation
// - reset pulse during read at least 100 ns
// - wait recovery time after ready and reset release
// - hold reset low 100 ns at power-up
// - keep 500 us from resume to suspend
// - partition ready does not mean engine free
// - poll bit 15 when strobe timing unmet
package frss_pkg;
    // clock and pin timing
    localparam int CLK_NS         = 50;
    localparam int US_NS          = 1000;
    localparam int US_CYC         = US_NS / CLK_NS;
    localparam int RST_READ_NS    = 100;
    localparam int RST_READ_CYC   = (RST_READ_NS + CLK_NS - 1) / CLK_NS;
    localparam int RST_ABORT_US   = 22;
    localparam int RECOVERY_NS    = 150;
    localparam int RECOVERY_CYC   = (RECOVERY_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACCESS_NS      = 80;
    localparam int READY_DROP_NS  = ACCESS_NS + 50;
    localparam int READY_DROP_CYC = (READY_DROP_NS + CLK_NS - 1) / CLK_NS;
    localparam int WE_LOW_NS      = 55;
    localparam int WE_LOW_CYC     = (WE_LOW_NS + CLK_NS - 1) / CLK_NS;
    localparam int RD_LOW_CYC     = (ACCESS_NS + CLK_NS - 1) / CLK_NS;
    localparam int STROBE_HIGH_NS = 25;
    localparam int STROBE_HIGH_CYC = (STROBE_HIGH_NS + CLK_NS - 1) / CLK_NS;
    // operation limits in microseconds
    localparam int PROG_MAX_US    = 200;
    localparam int PSUS_MAX_US    = 10;
    localparam int ESUS_MAX_US    = 20;
    localparam int PERASE_MAX_US  = 4000000;
    localparam int MERASE_MAX_US  = 5000000;
    localparam int CHIP_MAX_US    = 350000000;
    localparam int GAP_US         = 500;
    // register byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_ADDR  = 8'h04;
    localparam logic [7:0] REG_WDATA = 8'h08;
    localparam logic [7:0] REG_STAT  = 8'h0c;
    localparam logic [7:0] REG_IRQS  = 8'h10;
    localparam logic [7:0] REG_MASK  = 8'h14;
    // control fields
    localparam int CTRL_CMD_BIT    = 0;
    localparam int CTRL_RST_BIT    = 1;
    localparam int CTRL_RD_BIT     = 2;
    localparam int CTRL_GLOBAL_BIT = 3;
    localparam int CTRL_KIND_LSB   = 4;
    // status fields
    localparam int STAT_BUSY_BIT   = 16;
    localparam int STAT_OPACT_BIT  = 17;
    localparam int ALL_PARTITIONS_READY_BIT = 15;
    localparam int PARTITION_READY_BIT      = 7;
    // interrupt bits
    localparam int IRQ_W        = 3;
    localparam int IRQ_DONE     = 0;
    localparam int IRQ_TIMEOUT  = 1;
    localparam int IRQ_REFUSED  = 2;
    localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;

    // operation kind carried with a command
    typedef enum logic [2:0] {
        KIND_PLAIN  = 3'h0,
        KIND_PROG   = 3'h1,
        KIND_PERASE = 3'h2,
        KIND_MERASE = 3'h3,
        KIND_CHIP   = 3'h4,
        KIND_PSUS   = 3'h5,
        KIND_ESUS   = 3'h6,
        KIND_ERES   = 3'h7
    } frss_kind_e;

    // sequencer states
    typedef enum logic [8:0] {
        ST_IDLE    = 9'h001,
        ST_RST_LOW = 9'h002,
        ST_RST_REC = 9'h004,
        ST_WR_LOW  = 9'h008,
        ST_WR_HIGH = 9'h010,
        ST_SETTLE  = 9'h020,
        ST_RD_LOW  = 9'h040,
        ST_RD_GAP  = 9'h080,
        ST_GAP     = 9'h100
    } frss_state_e;
endpackage

// >>> core/frss_timer.sv
// microsecond tick divider and timeout counter
module frss_timer
    import frss_pkg::*;
#(
    parameter int W = 32
)(
    input  wire logic clk_i,
    input  wire logic rst_i,
    frss_tmr_if.tmr   t
);
    localparam logic [7:0] DIV_LAST = 8'(US_CYC - 1);

    logic [7:0]   div_reg,  div_next;
    logic [W-1:0] cnt_reg,  cnt_next;
    logic         tick_reg, tick_next;
    logic         exp_reg,  exp_next;

    // divider gives one-cycle microsecond enable; counter expires at zero
    always_comb begin
        tick_next = (div_reg == DIV_LAST);
        div_next  = tick_next ? 8'h00 : div_reg + 8'h01;
        cnt_next  = cnt_reg;
        exp_next  = exp_reg;
        if (t.start) begin
            cnt_next = t.limit;
            exp_next = 1'b0;
        end else if (tick_reg) begin
            if (cnt_reg == '0) begin
                exp_next = 1'b1;
            end else begin
                cnt_next = cnt_reg - 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_reg  <= 8'h00;
            cnt_reg  <= '0;
            tick_reg <= 1'b0;
            exp_reg  <= 1'b0;
        end else begin
            div_reg  <= div_next;
            cnt_reg  <= cnt_next;
            tick_reg <= tick_next;
            exp_reg  <= exp_next;
        end
    end

    assign t.us_tick = tick_reg;
    assign t.expired = exp_reg;
endmodule // frss_timer

// >>> core/frss_tmr_if.sv
// link between sequencer and microsecond timeout timer
interface frss_tmr_if #(
    parameter int W = 32
);
    logic         start;
    logic [W-1:0] limit;
    logic         us_tick;
    logic         expired;
    modport ctl (output start, output limit, input us_tick, input expired);
    modport tmr (input start, input limit, output us_tick, output expired);
endinterface

// >>> test/frss_flash.sv
// behavioural flash status model for the host bench
module frss_flash import frss_pkg::*; (
    input  wire logic        rst_n_i,
    input  wire logic        ce_n_i,
    input  wire logic        we_n_i,
    input  wire logic        oe_n_i,
    input  wire logic [15:0] dq_i,
    input  wire logic        other_busy_i,
    input  wire logic [31:0] dur_ns_i,
    output logic      [15:0] dq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    realtime     done_t = 0;
    logic [15:0] last   = 16'h0000;
    logic        part_rdy;
    logic        wr_n;
    // ready once the operation time has run out
    always #10 part_rdy = ($realtime >= done_t);
    // command taken when the first of the two write strobes rises
    assign wr_n = we_n_i | ce_n_i;
    always @(posedge wr_n) if (rst_n_i) begin
        if (dq_i == 16'h00b0) begin
            if (done_t > $realtime + 5000) done_t = $realtime + 5000;
        end else
            done_t = $realtime + dur_ns_i;
    end
    // reset aborts a running operation
    always @(negedge rst_n_i) done_t = $realtime + (part_rdy ? 50 : 5000);
    // status drive while selected, scrambled when released
    always @* begin
        if (!ce_n_i && !oe_n_i && rst_n_i) begin
            dq_o = 16'h0000;
            dq_o[ALL_PARTITIONS_READY_BIT] = part_rdy && !other_busy_i;
            dq_o[PARTITION_READY_BIT] = part_rdy;
            last = dq_o;
        end else
            dq_o = ~last;
    end
endmodule // frss_flash

// >>> test/frss_host_assertions.sv
// checker of host pin and bus sequencing
module frss_chk (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic flash_rst_n_o,
    input wire logic flash_ce_n_o,
    input wire logic flash_we_n_o,
    input wire logic flash_oe_n_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    pu_hold_a: assert property ($fell(rst_i) |-> !flash_rst_n_o ##1 !flash_rst_n_o)
        else $error("power-up reset pulse too short");
    rst_len_a: assert property ($fell(flash_rst_n_o) |=> !flash_rst_n_o)
        else $error("reset pulse too short");
    recov_a: assert property ($rose(flash_rst_n_o) |-> (flash_we_n_o && flash_oe_n_o)[*3])
        else $error("strobe inside recovery time");
    no_we_rst_a: assert property (!flash_rst_n_o |-> flash_we_n_o && flash_ce_n_o)
        else $error("strobe while reset low");
    wr_pulse_a: assert property ($fell(flash_we_n_o) |-> !flash_ce_n_o ##1 !flash_we_n_o
        ##1 flash_we_n_o)
        else $error("write pulse shape wrong");
    rd_excl_a: assert property (!flash_oe_n_o |-> flash_we_n_o)
        else $error("read and write strobes overlap");
    rd_pulse_a: assert property ($fell(flash_oe_n_o) |=> !flash_oe_n_o ##1 flash_oe_n_o)
        else $error("status read pulse wrong");
    bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
        else $error("bus answer wrong");
endmodule // frss_chk

bind frss_host frss_chk u_frss_chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
    .flash_rst_n_o, .flash_ce_n_o, .flash_we_n_o, .flash_oe_n_o);

// >>> test/tb_top.sv
// bench for the flash reset and suspend host
module tb_top import frss_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, we = 1'b0, ob = 1'b0;
    logic [7:0]  adr = 8'h00;
    logic [31:0] wd = 32'h0, rd, dat_o;
    logic        ack, irq, rst_n, ce_n, we_n, oe_n, dq_oe;
    logic [15:0] dq_o, fdq;
    logic [20:0] fa;
    int          dur = 0, fail_count = 0, compares = 0, cyc_n = 0, low_n = 0, t0;
    always #25 clk_i = ~clk_i;
    // cycle count, reset low length, hang guard
    always @(posedge clk_i) begin
        cyc_n <= cyc_n + 1;
        if (!rst_n) low_n <= low_n + 1;
        if (cyc_n == 60000) begin
            fail_count++;
            end_sim();
        end
    end
    frss_host #(.PERASE_TO_US(50), .MERASE_TO_US(50), .CHIP_TO_US(50), .GAP_LIMIT_US(5))
    u_frss_host (.clk_i, .rst_i, .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
        .wb_adr_i(adr), .wb_dat_i(wd), .wb_sel_i(4'hf), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .irq_o(irq), .flash_rst_n_o(rst_n), .flash_ce_n_o(ce_n), .flash_we_n_o(we_n),
        .flash_oe_n_o(oe_n), .flash_addr_o(fa), .flash_dq_i(dq_oe ? dq_o : fdq),
        .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe));
    frss_flash u_frss_flash (.rst_n_i(rst_n), .ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n),
        .dq_i(dq_o), .other_busy_i(ob), .dur_ns_i(dur), .dq_o(fdq));
    // one bus cycle, released after ack
    task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
        @(posedge clk_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        rd = dat_o;
        cyc <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        wb(a, 1'b0, 32'h0);
        chk(rd & m, e);
    endtask
    task automatic idle();
        do wb(REG_STAT, 1'b0, 32'h0); while (rd[STAT_BUSY_BIT] !== 1'b0);
    endtask
    task automatic cmd(input logic [2:0] k, input logic [15:0] d, input logic g);
        wb(REG_WDATA, 1'b1, {16'h0, d});
        wb(REG_CTRL, 1'b1, {25'h0, k, g, 3'h1});
    endtask
    task automatic end_sim();
        $display("compares=%0d fail_count=%0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        idle();
        rdc(REG_IRQS, 7, 1);
        rdc(REG_MASK, 7, 0);
        wb(REG_STAT, 1'b1, 32'hffff_ffff);
        rdc(8'h18, 32'hffff_ffff, 0);
        wb(REG_MASK, 1'b1, 7);
        @(posedge clk_i);
        chk(irq, 1);
        wb(REG_IRQS, 1'b1, 7);
        @(posedge clk_i);
        chk(irq, 0);
        $display("test registers done");
        dur = 20000;
        t0 = cyc_n;
        cmd(KIND_PERASE, 16'h0020, 1'b0);
        idle();
        chk({31'h0, (cyc_n - t0) >= 400}, 1);
        rdc(REG_IRQS, 7, 1);
        rdc(REG_STAT, 32'h3_8080, 32'h8080);
        wb(REG_IRQS, 1'b1, 7);
        ob <= 1'b1;
        dur = 2000;
        cmd(KIND_PERASE, 16'h0020, 1'b1);
        repeat (400) @(posedge clk_i);
        rdc(REG_STAT, 32'h1_8080, 32'h1_0080);
        ob <= 1'b0;
        idle();
        rdc(REG_IRQS, 7, 1);
        wb(REG_IRQS, 1'b1, 7);
        $display("test erase polling done");
        dur = 80000;
        cmd(KIND_PERASE, 16'h0020, 1'b0);
        idle();
        rdc(REG_IRQS, 7, 2);
        cmd(KIND_MERASE, 16'h0020, 1'b0);
        rdc(REG_IRQS, 7, 6);
        wb(REG_IRQS, 1'b1, 7);
        cmd(KIND_ESUS, 16'h00b0, 1'b0);
        idle();
        rdc(REG_IRQS, 7, 1);
        rdc(REG_STAT, 32'h2_0080, 32'h80);
        dur = 1000;
        cmd(KIND_ERES, 16'h00d0, 1'b0);
        idle();
        cmd(KIND_ESUS, 16'h00b0, 1'b0);
        repeat (30) @(posedge clk_i);
        chk(we_n, 1);
        rdc(REG_STAT, 32'h1_0000, 32'h1_0000);
        idle();
        wb(REG_IRQS, 1'b1, 7);
        $display("test suspend done");
        dur = 80000;
        cmd(KIND_PERASE, 16'h0020, 1'b0);
        idle();
        low_n = 0;
        wb(REG_CTRL, 1'b1, 2);
        idle();
        chk({31'h0, low_n >= RST_ABORT_US * US_CYC}, 1);
        low_n = 0;
        wb(REG_CTRL, 1'b1, 2);
        idle();
        chk(low_n, RST_READ_CYC);
        rdc(REG_IRQS, 1, 1);
        wb(REG_ADDR, 1'b1, 32'h0001_2345);
        wb(REG_CTRL, 1'b1, 32'h0000_000c);
        idle();
        chk(fa, 32'h0001_2345);
        rdc(REG_STAT, 32'h3_ffff, 32'h8080);
        rdc(REG_CTRL, 32'hff, 32'h28);
        $display("test reset done");
        end_sim();
    end
endmodule // tb_top
